// File: xramd_top.sv
// Data memory steering: internal decode, expanded RAM, external bus and control register
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module xramd_top (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Configuration and core side
    input  wire logic                  configSelect,
    input  wire logic                  doubleSpeed,
    input  wire logic                  codeMoveActive,
    input  wire logic [7:0]            intAddr,
    input  wire logic                  intIndirect,
    input  wire logic                  stackAccess,
    output logic [1:0]                 intTarget,
    input  wire expanded_onchip_ram_pkg::xramd_move_s move,
    output logic                       moveDone,
    output logic [7:0]                 moveRdata,
    // External bus pins
    input  wire logic [7:0]            port0In,
    output logic [7:0]                 port0Out,
    output logic                       port0Oe,
    output logic [7:0]                 port2Out,
    output logic                       port2Oe,
    output logic                       readStrobe_n,
    output logic                       writeStrobe_n,
    output logic                       addrLatch
);
    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [7:0] auxMemoryControl;
    logic [7:0] next_auxMemoryControl;
    logic       cfgLoaded;
    logic       busWrPend;
    logic       busRdPend;
    logic       next_busWrPend;
    logic       next_busRdPend;
    logic [7:0] p0s1, p0s2;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            p0s1 <= 8'h00;
            p0s2 <= 8'h00;
        end else begin
            p0s1 <= port0In;
            p0s2 <= p0s1;
        end
    end

    wire logic busAccess = hsel && htrans[1] && hready;
    wire logic regHit    = (haddr == expanded_onchip_ram_pkg::REG_AUX_BYTE);

    always_comb begin
        next_busWrPend        = busAccess && hwrite && regHit;
        next_busRdPend        = busAccess && !hwrite;
        next_auxMemoryControl = auxMemoryControl;
        if (!cfgLoaded) begin
            next_auxMemoryControl[expanded_onchip_ram_pkg::BIT_SELECT] = configSelect;
        end else if (busWrPend) begin
            next_auxMemoryControl = hwdata[7:0] & expanded_onchip_ram_pkg::AUX_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            auxMemoryControl <= expanded_onchip_ram_pkg::AUX_RESET;
            cfgLoaded        <= 1'b0;
            busWrPend        <= 1'b0;
            busRdPend        <= 1'b0;
            hrdata           <= 32'h0000_0000;
        end else begin
            auxMemoryControl <= next_auxMemoryControl;
            cfgLoaded        <= 1'b1;
            busWrPend        <= next_busWrPend;
            busRdPend        <= next_busRdPend;
            hrdata           <= (next_busRdPend && regHit)
                              ? {24'h00_0000, auxMemoryControl} : 32'h0000_0000;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // Internal data decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            intTarget <= expanded_onchip_ram_pkg::XRAMD_TGT_LOW;
        end else if (intAddr <= expanded_onchip_ram_pkg::ADDR_LOW_TOP) begin
            intTarget <= expanded_onchip_ram_pkg::XRAMD_TGT_LOW;
        end else if (intIndirect || stackAccess) begin
            intTarget <= expanded_onchip_ram_pkg::XRAMD_TGT_UPPER;
        end else begin
            intTarget <= expanded_onchip_ram_pkg::XRAMD_TGT_SFR;
        end
    end

    // ------------------------------------------------------------
    // Move engine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_LATCH, S_STROBE, S_DONE} xramd_state_e;
    xramd_state_e state, next_state;
    logic [7:0]   expanded_onchip_ram [expanded_onchip_ram_pkg::EXPANDED_ONCHIP_RAM_DEPTH];
    logic [7:0]   mData, next_mData;
    logic         mWrite, next_mWrite;
    logic         mLong, next_mLong;
    logic [7:0]   next_moveRdata;
    logic         next_moveDone;
    logic [7:0]   next_port0Out, next_port2Out;
    logic         next_port0Oe, next_port2Oe, next_rd_n, next_wr_n;
    logic         tmrStart, tmrActive, tmrDone;
    logic [4:0]   strobeLen;
    logic         xramHit, xramWe;
    logic [10:0]  visible;

    // Settings sampled when the move starts
    always_comb begin
        visible  = {1'b0, auxMemoryControl[expanded_onchip_ram_pkg::BIT_SIZE_HI:expanded_onchip_ram_pkg::BIT_SIZE_LO], 8'h00}
                 + expanded_onchip_ram_pkg::EXPANDED_ONCHIP_RAM_PAGE;
        xramHit  = !auxMemoryControl[expanded_onchip_ram_pkg::BIT_SELECT]
                 && (!move.usePointer || ({1'b0, move.addr} < {6'h00, visible}));
        strobeLen = mLong
                  ? expanded_onchip_ram_pkg::STROBE_LONG : expanded_onchip_ram_pkg::STROBE_SHORT;
    end

    xramd_strobe_timer u_timer (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .start   (tmrStart),
        .length  (strobeLen),
        .active  (tmrActive),
        .done    (tmrDone)
    );

    always_comb begin
        next_state     = state;
        next_mData     = mData;
        next_mWrite    = mWrite;
        next_mLong     = mLong;
        next_moveRdata = moveRdata;
        next_moveDone  = 1'b0;
        next_port0Out  = port0Out;
        next_port0Oe   = port0Oe;
        next_port2Out  = port2Out;
        next_port2Oe   = port2Oe;
        next_rd_n      = readStrobe_n;
        next_wr_n      = writeStrobe_n;
        tmrStart       = 1'b0;
        xramWe         = 1'b0;
        unique case (state)
            S_IDLE: begin
                if (move.req) begin
                    next_mData  = move.wdata;
                    next_mWrite = move.write;
                    next_mLong  = auxMemoryControl[expanded_onchip_ram_pkg::BIT_STRETCH];
                    if (xramHit) begin
                        xramWe         = move.write;
                        next_moveRdata = expanded_onchip_ram[move.usePointer ? move.addr[9:0]
                                                              : {2'b00, move.addr[7:0]}];
                        next_moveDone  = 1'b1;
                    end else begin
                        next_port0Out = move.addr[7:0];
                        next_port0Oe  = 1'b1;
                        next_port2Out = move.usePointer ? move.addr[15:8] : port2Out;
                        next_port2Oe  = move.usePointer;
                        next_state    = S_LATCH;
                    end
                end
            end
            S_LATCH: begin
                tmrStart     = 1'b1;
                next_port0Oe = mWrite;
                next_port0Out = mWrite ? mData : expanded_onchip_ram_pkg::PORT_IDLE;
                next_wr_n    = !mWrite;
                next_rd_n    = mWrite;
                next_state   = S_STROBE;
            end
            S_STROBE: begin
                if (tmrDone) begin
                    next_rd_n      = 1'b1;
                    next_wr_n      = 1'b1;
                    next_moveRdata = mWrite ? moveRdata : p0s2;
                    next_state     = S_DONE;
                end
            end
            S_DONE: begin
                next_port0Oe  = 1'b0;
                next_port2Oe  = 1'b0;
                next_moveDone = 1'b1;
                next_state    = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state         <= S_IDLE;
            mData         <= 8'h00;
            mWrite        <= 1'b0;
            mLong         <= 1'b0;
            moveRdata     <= 8'h00;
            moveDone      <= 1'b0;
            port0Out      <= expanded_onchip_ram_pkg::PORT_IDLE;
            port0Oe       <= 1'b0;
            port2Out      <= expanded_onchip_ram_pkg::PORT_IDLE;
            port2Oe       <= 1'b0;
            readStrobe_n  <= 1'b1;
            writeStrobe_n <= 1'b1;
        end else begin
            state         <= next_state;
            mData         <= next_mData;
            mWrite        <= next_mWrite;
            mLong         <= next_mLong;
            moveRdata     <= next_moveRdata;
            moveDone      <= next_moveDone;
            port0Out      <= next_port0Out;
            port0Oe       <= next_port0Oe;
            port2Out      <= next_port2Out;
            port2Oe       <= next_port2Oe;
            readStrobe_n  <= next_rd_n;
            writeStrobe_n <= next_wr_n;
        end
    end

    // Expanded RAM storage, no reset
    always_ff @(posedge clk_sys) begin
        if (xramWe) begin
            expanded_onchip_ram[move.usePointer ? move.addr[9:0] : {2'b00, move.addr[7:0]}] <= move.wdata;
        end
    end

    // ------------------------------------------------------------
    // Address latch strobe
    // ------------------------------------------------------------
    logic [2:0] aleCnt, next_aleCnt;
    logic       next_addrLatch;
    always_comb begin
        next_aleCnt = (aleCnt == 3'd0)
                    ? ((doubleSpeed ? expanded_onchip_ram_pkg::ALE_DIV_FAST : expanded_onchip_ram_pkg::ALE_DIV_STD) - 3'd1)
                    : aleCnt - 3'd1;
        if (auxMemoryControl[expanded_onchip_ram_pkg::BIT_QUIET]) begin
            next_addrLatch = (next_state == S_LATCH) || codeMoveActive;
        end else begin
            next_addrLatch = (aleCnt == 3'd0);
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aleCnt    <= 3'd0;
            addrLatch <= 1'b0;
        end else begin
            aleCnt    <= next_aleCnt;
            addrLatch <= next_addrLatch;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_sfr_direct;
        @(posedge clk_sys) disable iff (!rstn)
        (intAddr > expanded_onchip_ram_pkg::ADDR_LOW_TOP && !intIndirect && !stackAccess)
            |=> intTarget == expanded_onchip_ram_pkg::XRAMD_TGT_SFR;
    endproperty
    a_sfr_direct: assert property (p_sfr_direct) else $error("direct high not sfr");

    property p_upper_indirect;
        @(posedge clk_sys) disable iff (!rstn)
        (intAddr > expanded_onchip_ram_pkg::ADDR_LOW_TOP && (intIndirect || stackAccess))
            |=> intTarget == expanded_onchip_ram_pkg::XRAMD_TGT_UPPER;
    endproperty
    a_upper_indirect: assert property (p_upper_indirect) else $error("indirect high not upper");

    property p_low;
        @(posedge clk_sys) disable iff (!rstn)
        intAddr <= expanded_onchip_ram_pkg::ADDR_LOW_TOP |=> intTarget == expanded_onchip_ram_pkg::XRAMD_TGT_LOW;
    endproperty
    a_low: assert property (p_low) else $error("low area misrouted");

    property p_expanded_onchip_ram_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        (state == S_IDLE && move.req && xramHit)
            |=> readStrobe_n && writeStrobe_n && !port0Oe && $stable(port2Out) && moveDone;
    endproperty
    a_expanded_onchip_ram_quiet: assert property (p_expanded_onchip_ram_quiet) else $error("expanded_onchip_ram hit touched bus");

    property p_ext_select;
        @(posedge clk_sys) disable iff (!rstn)
        (state == S_IDLE && move.req && auxMemoryControl[expanded_onchip_ram_pkg::BIT_SELECT])
            |=> state == S_LATCH;
    endproperty
    a_ext_select: assert property (p_ext_select) else $error("select set stayed internal");

    property p_ptr_addr;
        @(posedge clk_sys) disable iff (!rstn)
        (state == S_IDLE && move.req && !xramHit && move.usePointer)
            |=> port2Out == $past(move.addr[15:8]) && port0Out == $past(move.addr[7:0]);
    endproperty
    a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address wrong");

    property p_write_strobe;
        @(posedge clk_sys) disable iff (!rstn)
        (state == S_LATCH && mWrite) |=> !writeStrobe_n && readStrobe_n;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("write strobe missing");

    property p_short_strobe;
        @(posedge clk_sys) disable iff (!rstn)
        $fell(readStrobe_n) && !mLong
            |-> !readStrobe_n [*6] ##1 readStrobe_n;
    endproperty
    a_short_strobe: assert property (p_short_strobe) else $error("strobe not 6 clocks");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rstn)
        (auxMemoryControl & ~expanded_onchip_ram_pkg::AUX_WRITE_MASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    c_expanded_onchip_ram_read: cover property (@(posedge clk_sys) disable iff (!rstn)
        state == S_IDLE && move.req && xramHit && !move.write);
    c_ext_write: cover property (@(posedge clk_sys) disable iff (!rstn)
        state == S_LATCH && mWrite);
    c_long_strobe: cover property (@(posedge clk_sys) disable iff (!rstn)
        $fell(readStrobe_n) && mLong);
endmodule
`default_nettype wire

// File: expanded_onchip_ram_pkg.sv
// Package: constants, register layout and carriers for the data memory steering block
package expanded_onchip_ram_pkg;

    localparam logic [7:0]  ADDR_LOW_TOP    = 8'h7F;
    localparam logic [7:0]  REG_AUX_INDEX   = 8'h8E;
    localparam logic [11:0] REG_AUX_BYTE    = 12'h238;
    localparam int          BIT_QUIET       = 0;
    localparam int          BIT_SELECT      = 1;
    localparam int          BIT_SIZE_LO     = 2;
    localparam int          BIT_SIZE_HI     = 3;
    localparam int          BIT_STRETCH     = 5;
    localparam logic [7:0]  AUX_WRITE_MASK  = 8'h2F;
    localparam logic [7:0]  AUX_RESET       = 8'h00;
    localparam logic [4:0]  STROBE_SHORT    = 5'd6;
    localparam logic [4:0]  STROBE_LONG     = 5'd30;
    localparam logic [2:0]  ALE_DIV_STD     = 3'd6;
    localparam logic [2:0]  ALE_DIV_FAST    = 3'd3;
    localparam logic [10:0] EXPANDED_ONCHIP_RAM_PAGE       = 11'h100;
    localparam int          EXPANDED_ONCHIP_RAM_DEPTH      = 1024;
    localparam logic [7:0]  PORT_IDLE       = 8'hFF;

    typedef enum logic [1:0] {
        XRAMD_TGT_LOW,
        XRAMD_TGT_UPPER,
        XRAMD_TGT_SFR
    } xramd_target_e;

    typedef struct packed {
        logic       req;
        logic       write;
        logic       usePointer;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xramd_move_s;

endpackage

// File: xramd_strobe_timer.sv
// Strobe length counter for external bus cycles
`timescale 1ns/1ps
`default_nettype none
module xramd_strobe_timer (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       start,
    input  wire logic [4:0] length,
    output logic            active,
    output logic            done
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic       next_active;
    logic       next_done;

    always_comb begin
        next_count  = count;
        next_active = active;
        next_done   = 1'b0;
        if (start) begin
            // One cycle of the strobe goes to the done flop
            next_count  = length - 5'd2;
            next_active = 1'b1;
        end else if (active) begin
            if (count == 5'd0) begin
                next_active = 1'b0;
                next_done   = 1'b1;
            end else begin
                next_count = count - 5'd1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count  <= 5'd0;
            active <= 1'b0;
            done   <= 1'b0;
        end else begin
            count  <= next_count;
            active <= next_active;
            done   <= next_done;
        end
    end
endmodule
`default_nettype wire

// File: xramd_ext_mem.sv
// External slow memory answering the strobed multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module xramd_ext_mem (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  port0Out,
    input  wire logic        port0Oe,
    input  wire logic [7:0]  port2Out,
    input  wire logic        readStrobe_n,
    input  wire logic        writeStrobe_n,
    output logic      [7:0]  port0In,
    output logic      [15:0] lastAddr
);
    logic [7:0] mem [65536];
    logic [7:0] wdata;
    logic [7:0] lastOut = 8'h00;
    logic       wrLow   = 1'b0;

    always_ff @(posedge clk_sys) begin
        // Address taken only while both strobes idle and no write is closing
        if (readStrobe_n && writeStrobe_n && port0Oe && !wrLow) begin
            lastAddr <= {port2Out, port0Out};
        end
        if (!writeStrobe_n) begin
            wdata <= port0Out;
        end
        if (writeStrobe_n && wrLow) begin
            mem[lastAddr] <= wdata;
        end
        wrLow <= !writeStrobe_n;
        if (!readStrobe_n) begin
            lastOut <= mem[lastAddr];
        end
    end

    // Released bus shows the inverse of the last byte driven
    assign port0In = !readStrobe_n ? mem[lastAddr] : ~lastOut;
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the data memory steering block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [11:0] AUX_ADDR = expanded_onchip_ram_pkg::REG_AUX_BYTE;
    logic                  clk_sys        = 1'b0;
    logic                  rstn           = 1'b0;
    logic                  hsel           = 1'b0;
    logic [11:0]           haddr          = 12'h000;
    logic [1:0]            htrans         = 2'b00;
    logic                  hwrite         = 1'b0;
    logic [31:0]           hwdata         = 32'h0000_0000;
    logic                  configSelect   = 1'b0;
    logic                  doubleSpeed    = 1'b0;
    logic                  codeMoveActive = 1'b0;
    logic [7:0]            intAddr        = 8'h00;
    logic                  intIndirect    = 1'b0;
    logic                  stackAccess    = 1'b0;
    expanded_onchip_ram_pkg::xramd_move_s move           = '0;
    wire logic             hready;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
    logic [1:0]            intTarget;
    logic                  moveDone;
    logic [7:0]            moveRdata;
    logic [7:0]            port0In;
    logic [7:0]            port0Out;
    logic                  port0Oe;
    logic [7:0]            port2Out;
    logic                  port2Oe;
    logic                  readStrobe_n;
    logic                  writeStrobe_n;
    logic                  addrLatch;
    logic [15:0]           lastAddr;
    int                    n_mismatch     = 0;
    int                    checks         = 0;

    assign hready = hreadyout;

    xramd_top dut (
        .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .configSelect(configSelect), .doubleSpeed(doubleSpeed),
        .codeMoveActive(codeMoveActive), .intAddr(intAddr), .intIndirect(intIndirect),
        .stackAccess(stackAccess), .intTarget(intTarget), .move(move),
        .moveDone(moveDone), .moveRdata(moveRdata), .port0In(port0In),
        .port0Out(port0Out), .port0Oe(port0Oe), .port2Out(port2Out), .port2Oe(port2Oe),
        .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .addrLatch(addrLatch)
    );

    xramd_ext_mem partner (
        .clk_sys(clk_sys), .port0Out(port0Out), .port0Oe(port0Oe), .port2Out(port2Out),
        .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .port0In(port0In), .lastAddr(lastAddr)
    );

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (hready !== 1'b1 && i < 50);
    endtask

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic do_move(input logic wr, input logic ptr, input logic [15:0] a,
                           input logic [7:0] wd, output logic ext, output int len);
        int i;
        ext = 1'b0;
        len = 0;
        @(posedge clk_sys);
        move <= '{req: 1'b1, write: wr, usePointer: ptr, addr: a, wdata: wd};
        @(posedge clk_sys);
        move.req <= 1'b0;
        for (i = 0; i < 100 && moveDone !== 1'b1; i++) begin
            @(negedge clk_sys);
            if (port0Oe || port2Oe || !readStrobe_n || !writeStrobe_n) ext = 1'b1;
            if (!readStrobe_n || !writeStrobe_n) len++;
        end
        check(moveDone, 1'b1);
    endtask

    task automatic count_ale(output int n);
        n = 0;
        repeat (60) begin
            @(negedge clk_sys);
            if (addrLatch === 1'b1) n++;
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic        e;
        int          len;
        int          n;
        int          s;
        // Address, indirect, stack, expected target
        logic [11:0] rows [8] = '{12'h100, 12'h108, 12'h7f0, 12'h7f8,
                                  12'ha02, 12'ha09, 12'h805, 12'hff2};
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk_sys);
            intAddr <= rows[i][11:4];
            intIndirect <= rows[i][3];
            stackAccess <= rows[i][2];
            @(posedge clk_sys);
            @(negedge clk_sys);
            check(intTarget, rows[i][1:0]);
        end
        ahb(1'b0, AUX_ADDR, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        check(hresp, 1'b0);
        ahb(1'b0, 12'h000, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        count_ale(n);
        check(n, 10);
        @(posedge clk_sys);
        doubleSpeed <= 1'b1;
        // Let the slow period in flight run out
        repeat (6) @(posedge clk_sys);
        count_ale(n);
        check(n, 20);
        ahb(1'b1, AUX_ADDR, 32'h0000_0001, rd);
        @(posedge clk_sys);
        doubleSpeed <= 1'b0;
        count_ale(n);
        check(n, 0);
        @(posedge clk_sys);
        codeMoveActive <= 1'b1;
        count_ale(n);
        check(n != 0, 1'b1);
        @(posedge clk_sys);
        codeMoveActive <= 1'b0;
        // Size boundaries: last visible byte internal, next one external
        for (s = 0; s < 4; s++) begin
            ahb(1'b1, AUX_ADDR, 32'(s << 2), rd);
            do_move(1'b1, 1'b1, 16'((s + 1) * 256 - 1), 8'(8'h40 + s), e, len);
            check(e, 1'b0);
            do_move(1'b0, 1'b1, 16'((s + 1) * 256 - 1), 8'h00, e, len);
            check(moveRdata, 32'(8'h40 + s));
            if (s < 3) begin
                do_move(1'b1, 1'b1, 16'((s + 1) * 256), 8'(8'h50 + s), e, len);
                check(len, 6);
                do_move(1'b0, 1'b1, 16'((s + 1) * 256), 8'h00, e, len);
                check(moveRdata, 32'(8'h50 + s));
            end
        end
        do_move(1'b0, 1'b0, 16'h03ff, 8'h00, e, len);
        check({e, moveRdata}, 9'h040);
        ahb(1'b1, AUX_ADDR, 32'h0000_0020, rd);
        do_move(1'b1, 1'b1, 16'h0200, 8'h77, e, len);
        check(len, 30);
        do_move(1'b0, 1'b1, 16'h0200, 8'h00, e, len);
        check(len, 30);
        check(moveRdata, 8'h77);
        ahb(1'b1, AUX_ADDR, 32'h0000_0002, rd);
        do_move(1'b1, 1'b0, 16'h0033, 8'h99, e, len);
        check({e, lastAddr[7:0]}, 9'h133);
        do_move(1'b0, 1'b0, 16'h0033, 8'h00, e, len);
        check(moveRdata, 8'h99);
        do_move(1'b1, 1'b1, 16'h1234, 8'hab, e, len);
        check(lastAddr, 16'h1234);
        do_move(1'b0, 1'b1, 16'h0034, 8'h00, e, len);
        check({e, lastAddr}, 17'h1_0034);
        do_move(1'b0, 1'b1, 16'h1234, 8'h00, e, len);
        check(moveRdata, 8'hab);
        // Second reset with the configuration select bit set
        @(posedge clk_sys);
        rstn <= 1'b0;
        configSelect <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        ahb(1'b0, AUX_ADDR, 32'h0000_0000, rd);
        check(rd, 32'h0000_0002);
        end_of_test();
    end

    initial begin
        #250000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
